// >>> wdc_watchdog_control.sv
// Purpose: Watchdog control register, timed access, watchdog count and reset cause
// Assumes: rst_i is the power-on reset; ext and power-fail resets arrive from pins
// Notes:   Registers on classic Wishbone, one aligned word each, data in bits 7:0
//
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps
module wdc_watchdog_control #(
    parameter int unsigned TIMEOUT_CYCLES = wdc_pkg::WDC_TIMEOUT_DEFAULT
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        ext_rst_i,
    input  wire logic        power_fail_rst_i,
    output logic             irq_o,
    output logic             wdt_irq_req_o,
    output logic             wdt_sys_reset_o,
    output logic             serial1_baud_double_o
);

    generate
        if (TIMEOUT_CYCLES < 2) begin : g_bad_timeout
            $error("TIMEOUT_CYCLES must be at least 2");
        end
        if (wdc_pkg::WDC_WINDOW_CYCLES < 1 || wdc_pkg::WDC_WINDOW_CYCLES > 15) begin : g_bad_window
            $error("window length does not fit its 4-bit counter");
        end
        if (wdc_pkg::WDC_RST_DELAY_CYCLES < 1 || wdc_pkg::WDC_RST_DELAY_CYCLES > 1024) begin : g_bad_delay
            $error("reset delay does not fit its 10-bit counter");
        end
    endgenerate

    // ==========================================================
    // Pin synchronisers
    logic ext_meta_q, ext_q, pf_meta_q, pf_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_meta_q <= 1'b0;
            ext_q      <= 1'b0;
            pf_meta_q  <= 1'b0;
            pf_q       <= 1'b0;
        end else begin
            ext_meta_q <= ext_rst_i;
            ext_q      <= ext_meta_q;
            pf_meta_q  <= power_fail_rst_i;
            pf_q       <= pf_meta_q;
        end
    end

    // ==========================================================
    // Bus decode
    logic        ack_q;
    logic        acc, wr, hit_ctrl, hit_key, hit_stat, hit_mask, hit_eie;
    logic [7:0]  wbyte;
    assign acc   = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr    = acc && wb_we_i && wb_sel_i[0];
    assign wbyte = wb_dat_i[7:0];

    always_comb begin
        hit_ctrl = 1'b0;
        hit_key  = 1'b0;
        hit_stat = 1'b0;
        hit_mask = 1'b0;
        hit_eie  = 1'b0;
        if (wb_adr_i == wdc_pkg::WDC_CTRL_ADDR) begin
            hit_ctrl = 1'b1;
        end else if (wb_adr_i == wdc_pkg::WDC_KEY_ADDR) begin
            hit_key = 1'b1;
        end else if (wb_adr_i == wdc_pkg::WDC_STATUS_ADDR) begin
            hit_stat = 1'b1;
        end else if (wb_adr_i == wdc_pkg::WDC_MASK_ADDR) begin
            hit_mask = 1'b1;
        end else if (wb_adr_i == wdc_pkg::WDC_EIE_ADDR) begin
            hit_eie = 1'b1;
        end
    end

    // ==========================================================
    // Timed-access unlock
    wdc_pkg::wdc_ta_state_type ta_state_q;
    logic [3:0] win_cnt_q;
    logic       win_open;
    assign win_open = (win_cnt_q != 4'h0);

    // Any other bus write between the two keys breaks the sequence
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ta_state_q <= wdc_pkg::WDC_TA_IDLE;
        end else if (wr) begin
            case (ta_state_q)
                wdc_pkg::WDC_TA_IDLE: begin
                    if (hit_key && wbyte == wdc_pkg::WDC_KEY_FIRST) begin
                        ta_state_q <= wdc_pkg::WDC_TA_ARMED;
                    end
                end
                default: begin
                    ta_state_q <= wdc_pkg::WDC_TA_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_cnt_q <= 4'h0;
        end else if (wr && hit_key && ta_state_q == wdc_pkg::WDC_TA_ARMED
                     && wbyte == wdc_pkg::WDC_KEY_SECOND) begin
            win_cnt_q <= 4'(wdc_pkg::WDC_WINDOW_CYCLES);
        end else if (win_open) begin
            win_cnt_q <= win_cnt_q - 4'h1;
        end
    end

    // ==========================================================
    // Control register
    wdc_pkg::wdc_ctrl_type ctrl_q;
    logic ctrl_wr, prot_wr, tmo, wd_rst_q, any_ext_rst;
    assign ctrl_wr     = wr && hit_ctrl;
    assign prot_wr     = ctrl_wr && win_open;
    assign any_ext_rst = ext_q || pf_q || wd_rst_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q             <= '0;
            ctrl_q.por         <= 1'b1;
        end else if (any_ext_rst) begin
            // Pattern 0x0x0xx0b: flags at 0 cleared, x bits kept
            ctrl_q.baud_double <= 1'b0;
            ctrl_q.irq_flag    <= 1'b0;
            ctrl_q.restart     <= 1'b0;
            if (pf_q) begin
                ctrl_q.cause   <= 1'b0;
            end else if (wd_rst_q) begin
                ctrl_q.cause   <= 1'b1;
            end
        end else begin
            if (ctrl_wr) begin
                ctrl_q.baud_double <= wbyte[wdc_pkg::WDC_BIT_BAUD];
                ctrl_q.cause       <= wbyte[wdc_pkg::WDC_BIT_WATCHDOG_RESET_CAUSE_FLAG];
            end
            if (prot_wr) begin
                ctrl_q.por    <= wbyte[wdc_pkg::WDC_BIT_POR];
                ctrl_q.rst_en <= wbyte[wdc_pkg::WDC_BIT_EWT];
            end
            // Time-out beats a same-cycle software clear
            if (tmo) begin
                ctrl_q.irq_flag <= 1'b1;
            end else if (prot_wr) begin
                ctrl_q.irq_flag <= wbyte[wdc_pkg::WDC_BIT_WATCHDOG_IRQ_FLAG];
            end
            ctrl_q.restart <= prot_wr && wbyte[wdc_pkg::WDC_BIT_RWT];
        end
    end

    // ==========================================================
    // Watchdog count and reset delay
    logic [31:0] wd_cnt_q;
    logic [9:0]  dly_cnt_q;
    logic        dly_run_q, restart_now, fire;
    assign restart_now = ctrl_q.restart || any_ext_rst;
    assign tmo         = !restart_now && (wd_cnt_q == TIMEOUT_CYCLES - 1);
    assign fire        = dly_run_q && (dly_cnt_q == 10'h0) && !restart_now;

    always_ff @(posedge clk_i) begin
        if (rst_i || restart_now || tmo) begin
            wd_cnt_q <= 32'h0000_0000;
        end else begin
            wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || restart_now) begin
            dly_run_q <= 1'b0;
            dly_cnt_q <= 10'h000;
        end else if (tmo && !dly_run_q) begin
            dly_run_q <= 1'b1;
            dly_cnt_q <= 10'(wdc_pkg::WDC_RST_DELAY_CYCLES - 1);
        end else if (dly_run_q) begin
            dly_run_q <= (dly_cnt_q != 10'h0);
            dly_cnt_q <= dly_cnt_q - 10'h001;
        end
    end

    // Reset only when enabled at expiry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_rst_q <= 1'b0;
        end else begin
            wd_rst_q <= fire && ctrl_q.rst_en;
        end
    end

    // ==========================================================
    // Interrupt enable, status and mask
    logic [7:0]                    eie_q;
    logic [wdc_pkg::WDC_EV_NUM-1:0] stat_q, mask_q, stat_d, ev;
    assign ev = {wd_rst_q, tmo};

    always_comb begin
        stat_d = stat_q;
        if (wr && hit_stat) begin
            stat_d = stat_q & ~wbyte[wdc_pkg::WDC_EV_NUM-1:0];
        end
        stat_d = stat_d | ev;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= '0;
            mask_q <= wdc_pkg::WDC_MASK_RESET;
            eie_q  <= wdc_pkg::WDC_EIE_RESET;
            irq_o  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_o  <= |(stat_d & mask_q);
            if (wr && hit_mask) begin
                mask_q <= wbyte[wdc_pkg::WDC_EV_NUM-1:0];
            end
            if (wr && hit_eie) begin
                eie_q <= wbyte;
            end
        end
    end

    // ==========================================================
    // Outputs and read data
    logic [7:0] ctrl_byte;
    assign ctrl_byte = {ctrl_q.baud_double, ctrl_q.por, 2'b00, ctrl_q.irq_flag,
                        ctrl_q.cause, ctrl_q.rst_en, ctrl_q.restart};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_irq_req_o         <= 1'b0;
            wdt_sys_reset_o       <= 1'b0;
            serial1_baud_double_o <= 1'b0;
        end else begin
            wdt_irq_req_o         <= ctrl_q.irq_flag && eie_q[wdc_pkg::WDC_BIT_EIE_WD];
            wdt_sys_reset_o       <= wd_rst_q;
            serial1_baud_double_o <= ctrl_q.baud_double;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q    <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_q    <= acc;
            wb_dat_o <= 32'h0000_0000;
            if (acc && !wb_we_i) begin
                if (hit_ctrl) begin
                    wb_dat_o[7:0] <= ctrl_byte;
                end else if (hit_stat) begin
                    wb_dat_o[wdc_pkg::WDC_EV_NUM-1:0] <= stat_q;
                end else if (hit_mask) begin
                    wb_dat_o[wdc_pkg::WDC_EV_NUM-1:0] <= mask_q;
                end else if (hit_eie) begin
                    wb_dat_o[7:0] <= eie_q;
                end
            end
        end
    end
    assign wb_ack_o = ack_q;

    // ==========================================================
    // Check helper: edges since the reset delay began
    // Counter instead of a long plain delay in the checks
    logic [10:0] dly_age_q;
    always_ff @(posedge clk_i) begin
        if (rst_i || restart_now) begin
            dly_age_q <= 11'h000;
        end else if (tmo && !dly_run_q) begin
            dly_age_q <= 11'h001;
        end else if (dly_run_q) begin
            dly_age_q <= dly_age_q + 11'h001;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    power_on_flag_a: assert property ($past(rst_i) |-> ctrl_q.por)
        else $error("power-on flag not set after power-on reset");
    irq_flag_set_a: assert property (tmo |=> ctrl_q.irq_flag)
        else $error("interrupt flag missed a time-out");
    restart_clear_a: assert property (ctrl_q.restart |=> !ctrl_q.restart && wd_cnt_q == 32'h0)
        else $error("restart did not self-clear or zero the count");
    reset_delay_a: assert property (dly_run_q && dly_age_q == 11'(wdc_pkg::WDC_RST_DELAY_CYCLES)
        && ctrl_q.rst_en && !restart_now |=> wd_rst_q)
        else $error("watchdog reset not 512 clocks after time-out");
    reset_early_a: assert property (wd_rst_q |-> dly_age_q == 11'(wdc_pkg::WDC_RST_DELAY_CYCLES + 1))
        else $error("watchdog reset before the delay ran out");
    no_reset_dis_a: assert property (!ctrl_q.rst_en |=> !wd_rst_q)
        else $error("watchdog reset while disabled");
    cause_set_a: assert property (wd_rst_q && !pf_q |=> ctrl_q.cause)
        else $error("reset-cause flag not set by watchdog reset");
    ext_pattern_a: assert property (ext_q && !pf_q && !wd_rst_q |=>
        !ctrl_q.baud_double && !ctrl_q.irq_flag && !ctrl_q.restart && $stable(ctrl_q.cause))
        else $error("external reset pattern wrong");
    rst_en_kept_a: assert property (any_ext_rst |=> $stable(ctrl_q.rst_en))
        else $error("reset enable changed by non power-on reset");
    prot_locked_a: assert property (!win_open |=> $stable(ctrl_q.rst_en) && $stable(ctrl_q.por))
        else $error("protected bit written outside window");
    window_len_a: assert property ($rose(win_open) |-> win_open[*8] ##1 win_open[*4] ##1 !win_open)
        else $error("timed-access window length wrong");
    irq_req_a: assert property (ctrl_q.irq_flag && eie_q[wdc_pkg::WDC_BIT_EIE_WD] |=> wdt_irq_req_o)
        else $error("interrupt request not forwarded");
    cause_kept_a: assert property (!ctrl_q.rst_en && !wd_rst_q && !ctrl_wr && !pf_q |=> $stable(ctrl_q.cause))
        else $error("reset-cause flag changed while reset disabled");
    restart_delay_a: assert property (ctrl_q.restart |=> !dly_run_q)
        else $error("restart did not cancel the reset delay");
    baud_out_a: assert property (1'b1 |=> serial1_baud_double_o == $past(ctrl_q.baud_double))
        else $error("baud double output does not follow its bit");
    pf_cause_a: assert property (pf_q |=> !ctrl_q.cause)
        else $error("power-fail reset left the reset-cause flag set");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    por_kept_a: assert property (ctrl_q.por && !prot_wr |=> ctrl_q.por)
        else $error("power-on flag cleared without a software write");
    irq_flag_kept_a: assert property (ctrl_q.irq_flag && !prot_wr && !any_ext_rst |=> ctrl_q.irq_flag)
        else $error("interrupt flag cleared by hardware");
    window_key_a: assert property (!win_open && !(wr && hit_key) |=> !win_open)
        else $error("window opened without a key write");
    key_abort_a: assert property (ta_state_q == wdc_pkg::WDC_TA_ARMED && wr |=> ta_state_q == wdc_pkg::WDC_TA_IDLE)
        else $error("unlock sequence not reset after second write");
    irq_masked_a: assert property (mask_q == '0 |=> !irq_o)
        else $error("interrupt output high with all events masked");
    stat_set_a: assert property (tmo |=> stat_q[wdc_pkg::WDC_EV_TIMEOUT])
        else $error("time-out status bit not set");

    timeout_c: cover property (tmo);
    wd_reset_c: cover property (wd_rst_q);
    window_write_c: cover property (prot_wr);
    ext_reset_c: cover property (ext_q);
    restart_c: cover property (ctrl_q.restart);

endmodule

// >>> wdc_pkg.sv
// Purpose: Constants and types for the watchdog control and reset-cause block
// Assumes: 25 MHz core clock, classic Wishbone register access
// Notes:   How it works list below; offsets are byte addresses
// How it works
// - Power-on reset sets the power-on flag; only software writes clear it
// - Time-out sets the watchdog interrupt flag; software writes and every reset clear it
// - Watchdog reset sets the reset-cause flag; software or power-fail reset clears it
// - With reset enable clear, watchdog logic never touches the reset-cause flag
// - Reset enable set lets a time-out produce a system reset; clear means none
// - Writing one to restart zeroes the count; the restart bit then self-clears
// - Time-out raises the interrupt if enabled, reset follows 512 clocks later
// - External reset loads the control register with pattern 0x0x0xx0b
// - Reset-cause flag: 1 on watchdog reset, 0 on power resets, kept on external
// - Reset enable cleared by power-on reset or a timed-access write, untouched by other resets
// - All bits readable; protected bits writable only inside a timed-access window
// - Baud double bit set doubles serial port 1 rate in modes 1 to 3
package wdc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] WDC_CTRL_ADDR   = 8'hd8;
    localparam logic [7:0] WDC_KEY_ADDR    = 8'hdc;
    localparam logic [7:0] WDC_STATUS_ADDR = 8'he0;
    localparam logic [7:0] WDC_MASK_ADDR   = 8'he4;
    localparam logic [7:0] WDC_EIE_ADDR    = 8'he8;

    // ==========================================================
    // Field positions
    localparam int WDC_BIT_BAUD   = 7;
    localparam int WDC_BIT_POR    = 6;
    localparam int WDC_BIT_WATCHDOG_IRQ_FLAG   = 3;
    localparam int WDC_BIT_WATCHDOG_RESET_CAUSE_FLAG   = 2;
    localparam int WDC_BIT_EWT    = 1;
    localparam int WDC_BIT_RWT    = 0;
    localparam int WDC_BIT_EIE_WD = 4;
    localparam int WDC_EV_TIMEOUT = 0;
    localparam int WDC_EV_WDRST   = 1;
    localparam int WDC_EV_NUM     = 2;

    // ==========================================================
    // Key values and timing
    localparam logic [7:0] WDC_KEY_FIRST  = 8'haa;
    localparam logic [7:0] WDC_KEY_SECOND = 8'h55;
    localparam int WDC_CLOCKS_PER_MC   = 4;
    localparam int WDC_WINDOW_MC       = 3;
    localparam int WDC_WINDOW_CYCLES   = WDC_CLOCKS_PER_MC * WDC_WINDOW_MC;
    localparam int WDC_RST_DELAY_CYCLES = 512;
    localparam int WDC_TIMEOUT_DEFAULT = 131072;

    // ==========================================================
    // Reset values
    localparam logic [7:0] WDC_EIE_RESET  = 8'h00;
    localparam logic [1:0] WDC_MASK_RESET = 2'h0;

    typedef struct packed {
        logic baud_double;
        logic por;
        logic irq_flag;
        logic cause;
        logic rst_en;
        logic restart;
    } wdc_ctrl_type;

    typedef enum logic {WDC_TA_IDLE, WDC_TA_ARMED} wdc_ta_state_type;

endpackage

// >>> testbench.sv
// Purpose: Self-checking bench for the watchdog control and reset-cause block
// Assumes: Time-out shortened to 16 clocks so the 512-clock reset delay dominates
// Notes:   Interrupt flag bit 3 is masked where back-to-back time-outs keep setting it
`timescale 1ns/10ps
module testbench;
    localparam int          TMO   = 16;
    localparam int          LIMIT = 20000;
    logic                   clk_i            = 1'b0;
    logic                   rst_i            = 1'b1;
    logic                   wb_cyc_i         = 1'b0;
    logic                   wb_stb_i         = 1'b0;
    logic                   wb_we_i          = 1'b0;
    logic            [7:0]  wb_adr_i         = 8'h00;
    logic            [3:0]  wb_sel_i         = 4'h0;
    logic            [31:0] wb_dat_i         = 32'h0000_0000;
    logic            [31:0] wb_dat_o;
    logic                   wb_ack_o;
    logic                   ext_rst_i        = 1'b0;
    logic                   power_fail_rst_i = 1'b0;
    logic                   irq_o;
    logic                   wdt_irq_req_o;
    logic                   wdt_sys_reset_o;
    logic                   serial1_baud_double_o;
    int                     err_total        = 0;
    int                     check_count      = 0;
    int                     cyc_count        = 0;
    logic            [31:0] d;
    int                     n;

    wdc_watchdog_control #(.TIMEOUT_CYCLES(TMO)) i_dut (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .wb_cyc_i              (wb_cyc_i),
        .wb_stb_i              (wb_stb_i),
        .wb_we_i               (wb_we_i),
        .wb_adr_i              (wb_adr_i),
        .wb_sel_i              (wb_sel_i),
        .wb_dat_i              (wb_dat_i),
        .wb_dat_o              (wb_dat_o),
        .wb_ack_o              (wb_ack_o),
        .ext_rst_i             (ext_rst_i),
        .power_fail_rst_i      (power_fail_rst_i),
        .irq_o                 (irq_o),
        .wdt_irq_req_o         (wdt_irq_req_o),
        .wdt_sys_reset_o       (wdt_sys_reset_o),
        .serial1_baud_double_o (serial1_baud_double_o)
    );

    always #20 clk_i = ~clk_i;

    // ==========================================================
    // Shared tasks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Hang guard: counts as a mismatch, then closes the run
    always @(posedge clk_i) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == LIMIT) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Classic cycle: hold until ack sampled, then one idle cycle; a lost ack ends in the hang guard
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd, output logic [31:0] rd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= {24'h00_0000, wd};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
        logic [31:0] x;
        bus(1'b1, adr, wd, x);
    endtask

    task automatic rd(input logic [7:0] adr, output logic [31:0] x);
        bus(1'b0, adr, 8'h00, x);
    endtask

    task automatic unlock();
        wr(wdc_pkg::WDC_KEY_ADDR, wdc_pkg::WDC_KEY_FIRST);
        wr(wdc_pkg::WDC_KEY_ADDR, wdc_pkg::WDC_KEY_SECOND);
    endtask

    task automatic pulse(input int which);
        if (which == 0) ext_rst_i <= 1'b1;
        else power_fail_rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        ext_rst_i        <= 1'b0;
        power_fail_rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_and_map();
        rd(wdc_pkg::WDC_CTRL_ADDR, d);
        check("ctrl after power-on", d, 32'h0000_0040);
        rd(wdc_pkg::WDC_KEY_ADDR, d);
        check("key readback", d, 32'h0000_0000);
        wr(8'hf0, 8'hff);
        rd(8'hf0, d);
        check("unmapped read", d, 32'h0000_0000);
        repeat (40) @(posedge clk_i);
        check("irq req with enable off", {31'h0, wdt_irq_req_o}, 32'h0000_0000);
        rd(wdc_pkg::WDC_CTRL_ADDR, d);
        check("flag after time-out", d & 32'h0000_0008, 32'h0000_0008);
        // Reset enable still clear: no system reset over a full delay span
        n = 0;
        repeat (700) begin
            @(posedge clk_i);
            if (wdt_sys_reset_o !== 1'b0) n++;
        end
        check("reset pulses while disabled", n, 0);
        rd(wdc_pkg::WDC_CTRL_ADDR, d);
        check("cause while disabled", d & 32'h0000_0004, 32'h0000_0000);
        $display("test reset_and_map done");
    endtask

    task automatic t_free_and_protected();
        wr(wdc_pkg::WDC_CTRL_ADDR, 8'hff);
        rd(wdc_pkg::WDC_CTRL_ADDR, d);
        check("ctrl after open write", d & 32'h0000_00f7, 32'h0000_00c4);
        check("baud double out", {31'h0, serial1_baud_double_o}, 32'h0000_0001);
        wr(wdc_pkg::WDC_CTRL_ADDR, 8'h00);
        rd(wdc_pkg::WDC_CTRL_ADDR, d);
        check("power-on flag kept", d & 32'h0000_00f7, 32'h0000_0040);
        check("baud double off", {31'h0, serial1_baud_double_o}, 32'h0000_0000);
        $display("test free_and_protected done");
    endtask

    task automatic t_watchdog_reset();
        wr(wdc_pkg::WDC_EIE_ADDR, 8'h10);
        unlock();
        wr(wdc_pkg::WDC_CTRL_ADDR, 8'h83);
        rd(wdc_pkg::WDC_CTRL_ADDR, d);
        check("unlocked write", d & 32'h0000_00f7, 32'h0000_0082);
        n = 0;
        while (wdt_irq_req_o !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        check("irq req after time-out", {31'h0, wdt_irq_req_o}, 32'h0000_0001);
        n = 0;
        while (wdt_sys_reset_o !== 1'b1 && n < 700) begin
            @(posedge clk_i);
            n++;
        end
        check("reset delay", n, wdc_pkg::WDC_RST_DELAY_CYCLES);
        repeat (3) @(posedge clk_i);
        rd(wdc_pkg::WDC_CTRL_ADDR, d);
        check("ctrl after watchdog reset", d & 32'h0000_00f7, 32'h0000_0006);
        rd(wdc_pkg::WDC_STATUS_ADDR, d);
        check("reset event status", d & 32'h0000_0002, 32'h0000_0002);
        $display("test watchdog_reset done");
    endtask

    task automatic t_irq_and_abort();
        check("irq masked", {31'h0, irq_o}, 32'h0000_0000);
        wr(wdc_pkg::WDC_MASK_ADDR, 8'h02);
        repeat (3) @(posedge clk_i);
        check("irq unmasked", {31'h0, irq_o}, 32'h0000_0001);
        wr(wdc_pkg::WDC_STATUS_ADDR, 8'h02);
        repeat (3) @(posedge clk_i);
        check("irq after clear", {31'h0, irq_o}, 32'h0000_0000);
        // Foreign write between the two key bytes must void the unlock
        wr(wdc_pkg::WDC_KEY_ADDR, wdc_pkg::WDC_KEY_FIRST);
        wr(wdc_pkg::WDC_EIE_ADDR, 8'h10);
        wr(wdc_pkg::WDC_KEY_ADDR, wdc_pkg::WDC_KEY_SECOND);
        wr(wdc_pkg::WDC_CTRL_ADDR, 8'h00);
        rd(wdc_pkg::WDC_CTRL_ADDR, d);
        check("aborted unlock", d & 32'h0000_00f7, 32'h0000_0002);
        $display("test irq_and_abort done");
    endtask

    task automatic t_other_resets();
        wr(wdc_pkg::WDC_CTRL_ADDR, 8'h84);
        pulse(0);
        rd(wdc_pkg::WDC_CTRL_ADDR, d);
        check("ctrl after external reset", d & 32'h0000_00f7, 32'h0000_0006);
        pulse(1);
        rd(wdc_pkg::WDC_CTRL_ADDR, d);
        check("ctrl after power-fail", d & 32'h0000_00f7, 32'h0000_0002);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(wdc_pkg::WDC_CTRL_ADDR, d);
        check("ctrl after second power-on", d, 32'h0000_0040);
        $display("test other_resets done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset_and_map();
        t_free_and_protected();
        t_watchdog_reset();
        t_irq_and_abort();
        t_other_resets();
        give_verdict();
    end
endmodule
